// [logic/tbe_pkg.sv]
// constants and types shared by the two-wire byte memory slave
`default_nettype none
package tbe_pkg;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BITS = 4;
    localparam int MEM_DEPTH = 16;
    localparam int CNT_BITS = 4;
    localparam logic [CNT_BITS-1:0] CNT_LAST = 4'h7;
    localparam logic [CNT_BITS-1:0] CNT_FULL = 4'h8;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_BITS-1:0] CNT_ONE = 4'h1;
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 6;
    localparam int ADDR_MSB = 5;
    localparam int ADDR_LSB = 2;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam int CLK_HZ = 25000000;
    localparam int MS_PER_S = 1000;
    localparam int WR_TIME_MS = 5;
    localparam int WR_CYCLES = WR_TIME_MS * (CLK_HZ / MS_PER_S);
    localparam int SYNC_LINES = 3;
    localparam int SYNC_SCL = 0;
    localparam int SYNC_SDA = 1;
    localparam int SYNC_TOG = 2;

    typedef enum logic [2:0] {
        TBE_IDLE = 3'h0,
        TBE_CMD = 3'h1,
        TBE_WDATA = 3'h2,
        TBE_WRITE = 3'h3,
        TBE_RDATA = 3'h4,
        TBE_IGNORE = 3'h5
    } tbe_state_t;
endpackage
`default_nettype wire

// [logic/tbe_bit_if.sv]
// carrier for a received bit and its event toggle from the link clock domain
`default_nettype none
interface tbe_bit_if;
    logic bit_val;
    logic bit_tog;
    modport src (output bit_val, output bit_tog);
    modport dst (input bit_val, input bit_tog);
endinterface
`default_nettype wire

// [logic/tbe_scl_capture.sv]
// link clock domain: samples the data line on each rising serial clock
`default_nettype none
module tbe_scl_capture (
    input wire logic scl,
    input wire logic rst,
    input wire logic sda_i,
    tbe_bit_if.src bits
);
    logic bit_q;
    logic bit_d;
    logic tog_q;
    logic tog_d;

    always_comb begin
        bit_d = sda_i;
        tog_d = ~tog_q;
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            bit_q <= 1'b0;
            tog_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
            tog_q <= tog_d;
        end
    end

    assign bits.bit_val = bit_q;
    assign bits.bit_tog = tog_q;
endmodule
`default_nettype wire

// [logic/tbe_array.sv]
// byte array held in flip-flops with one write port and an indexed read
`default_nettype none
module tbe_array #(
    parameter int DEPTH = tbe_pkg::MEM_DEPTH,
    parameter int WIDTH = tbe_pkg::BYTE_BITS,
    parameter int AW = tbe_pkg::ADDR_BITS
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];

    if (DEPTH != (1 << AW)) begin : g_chk
        $error("array depth must match address width");
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (we) begin
            mem_d[addr] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
        end
    end

    assign rdata = mem_q[addr];
endmodule
`default_nettype wire

// [logic/tbe_top.sv]
// two-wire byte memory slave: condition detection, command sequencer, read driver
// Contract
// - data changes only while clock low
// - watch lines, act only after start
// - start during input aborts, awaits command
// - stop during input resets to standby
// - no start/stop while reading or writing
// - control byte: 01 command selects write
// - control byte: 10 command selects read
// - eight data bits, then program array
// - ignore all inputs during array write
// - start/stop before last bit clears counters
// - write end returns to standby itself
// - read loads byte, shifts eight out
// - after eighth read bit enter standby
// - start/stop aborts read command input
// - second don't-care bit ignores start/stop
// - output drives both levels actively
// - sixteen bytes, four address bits
// - write cycle within five milliseconds
`default_nettype none
module tbe_top #(
    parameter int WR_CYCLES = tbe_pkg::WR_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic write_busy
);
    localparam int TW = $clog2(WR_CYCLES + 1);

    if (WR_CYCLES < 1) begin : g_chk
        $error("write cycle count must be at least one");
    end

    tbe_bit_if bits ();

    // rising-edge capture in the serial clock domain
    tbe_scl_capture u_cap (
        .scl(scl),
        .rst(rst),
        .sda_i(sda_i),
        .bits(bits)
    );

    // two-flop synchronisers plus one delayed copy for edge detection
    logic [tbe_pkg::SYNC_LINES-1:0] raw;
    logic [tbe_pkg::SYNC_LINES-1:0] s1_q;
    logic [tbe_pkg::SYNC_LINES-1:0] s2_q;
    logic [tbe_pkg::SYNC_LINES-1:0] s3_q;

    assign raw[tbe_pkg::SYNC_SCL] = scl;
    assign raw[tbe_pkg::SYNC_SDA] = sda_i;
    assign raw[tbe_pkg::SYNC_TOG] = bits.bit_tog;

    for (genvar g = 0; g < tbe_pkg::SYNC_LINES; g++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
                s3_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= raw[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
            end
        end
    end

    // data line edge while clock held high
    function automatic logic line_cond(input logic scl_now, input logic from_lvl,
                                       input logic prev, input logic now);
        line_cond = scl_now && (prev == from_lvl) && (now != from_lvl);
    endfunction

    logic scl_s;
    logic start_det;
    logic stop_det;
    logic bit_ev;
    logic scl_fall;

    assign scl_s = s2_q[tbe_pkg::SYNC_SCL];
    assign start_det = line_cond(scl_s && s3_q[tbe_pkg::SYNC_SCL], 1'b1,
                                 s3_q[tbe_pkg::SYNC_SDA], s2_q[tbe_pkg::SYNC_SDA]);
    assign stop_det = line_cond(scl_s && s3_q[tbe_pkg::SYNC_SCL], 1'b0,
                                s3_q[tbe_pkg::SYNC_SDA], s2_q[tbe_pkg::SYNC_SDA]);
    assign bit_ev = s2_q[tbe_pkg::SYNC_TOG] ^ s3_q[tbe_pkg::SYNC_TOG];
    assign scl_fall = s3_q[tbe_pkg::SYNC_SCL] && !scl_s;

    tbe_pkg::tbe_state_t state_q;
    tbe_pkg::tbe_state_t state_d;
    logic [tbe_pkg::CNT_BITS-1:0] cnt_q;
    logic [tbe_pkg::CNT_BITS-1:0] cnt_d;
    logic [tbe_pkg::BYTE_BITS-1:0] sh_q;
    logic [tbe_pkg::BYTE_BITS-1:0] sh_d;
    logic [tbe_pkg::ADDR_BITS-1:0] addr_q;
    logic [tbe_pkg::ADDR_BITS-1:0] addr_d;
    logic [TW-1:0] timer_q;
    logic [TW-1:0] timer_d;
    logic sda_o_q;
    logic sda_o_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic mem_we;
    logic [tbe_pkg::BYTE_BITS-1:0] mem_rdata;
    logic [tbe_pkg::BYTE_BITS-1:0] rx_byte;
    logic [1:0] cmd;

    assign rx_byte = {sh_q[tbe_pkg::BYTE_BITS-2:0], bits.bit_val};
    assign cmd = rx_byte[tbe_pkg::CMD_MSB:tbe_pkg::CMD_LSB];

    tbe_array u_mem (
        .clk(clk),
        .we(mem_we),
        .addr(addr_q),
        .wdata(rx_byte),
        .rdata(mem_rdata)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        addr_d = addr_q;
        timer_d = timer_q;
        sda_o_d = sda_o_q;
        sda_oe_d = sda_oe_q;
        mem_we = 1'b0;
        case (state_q)
            tbe_pkg::TBE_IDLE, tbe_pkg::TBE_IGNORE: begin
                if (start_det) begin
                    state_d = tbe_pkg::TBE_CMD;
                    cnt_d = tbe_pkg::CNT_ZERO;
                end
            end
            tbe_pkg::TBE_CMD: begin
                if (start_det && cnt_q != tbe_pkg::CNT_LAST) begin
                    cnt_d = tbe_pkg::CNT_ZERO;
                end else if (stop_det && cnt_q != tbe_pkg::CNT_LAST) begin
                    state_d = tbe_pkg::TBE_IDLE;
                    cnt_d = tbe_pkg::CNT_ZERO;
                end else if (bit_ev) begin
                    sh_d = rx_byte;
                    cnt_d = cnt_q + tbe_pkg::CNT_ONE;
                    if (cnt_q == tbe_pkg::CNT_LAST) begin
                        cnt_d = tbe_pkg::CNT_ZERO;
                        addr_d = rx_byte[tbe_pkg::ADDR_MSB:tbe_pkg::ADDR_LSB];
                        if (cmd == tbe_pkg::CMD_WRITE) begin
                            state_d = tbe_pkg::TBE_WDATA;
                        end else if (cmd == tbe_pkg::CMD_READ) begin
                            state_d = tbe_pkg::TBE_RDATA;
                        end else begin
                            state_d = tbe_pkg::TBE_IGNORE;
                        end
                    end
                end
            end
            tbe_pkg::TBE_WDATA: begin
                if (start_det) begin
                    state_d = tbe_pkg::TBE_CMD;
                    cnt_d = tbe_pkg::CNT_ZERO;
                end else if (stop_det) begin
                    state_d = tbe_pkg::TBE_IDLE;
                    cnt_d = tbe_pkg::CNT_ZERO;
                end else if (bit_ev) begin
                    sh_d = rx_byte;
                    cnt_d = cnt_q + tbe_pkg::CNT_ONE;
                    if (cnt_q == tbe_pkg::CNT_LAST) begin
                        mem_we = 1'b1;
                        cnt_d = tbe_pkg::CNT_ZERO;
                        timer_d = TW'(WR_CYCLES);
                        state_d = tbe_pkg::TBE_WRITE;
                    end
                end
            end
            tbe_pkg::TBE_WRITE: begin
                sda_oe_d = 1'b0;
                if (timer_q <= TW'(1)) begin
                    timer_d = '0;
                    cnt_d = tbe_pkg::CNT_ZERO;
                    state_d = tbe_pkg::TBE_IDLE;
                end else begin
                    timer_d = timer_q - TW'(1);
                end
            end
            tbe_pkg::TBE_RDATA: begin
                // conditions are not looked at here
                if (scl_fall) begin
                    if (cnt_q == tbe_pkg::CNT_FULL) begin
                        sda_oe_d = 1'b0;
                        cnt_d = tbe_pkg::CNT_ZERO;
                        state_d = tbe_pkg::TBE_IDLE;
                    end else begin
                        if (cnt_q == tbe_pkg::CNT_ZERO) begin
                            sda_o_d = mem_rdata[tbe_pkg::BYTE_BITS-1];
                            sh_d = {mem_rdata[tbe_pkg::BYTE_BITS-2:0], 1'b0};
                        end else begin
                            sda_o_d = sh_q[tbe_pkg::BYTE_BITS-1];
                            sh_d = {sh_q[tbe_pkg::BYTE_BITS-2:0], 1'b0};
                        end
                        sda_oe_d = 1'b1;
                        cnt_d = cnt_q + tbe_pkg::CNT_ONE;
                    end
                end
            end
            default: begin
                state_d = tbe_pkg::TBE_IDLE;
                cnt_d = tbe_pkg::CNT_ZERO;
                sda_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= tbe_pkg::TBE_IDLE;
            cnt_q <= tbe_pkg::CNT_ZERO;
            sh_q <= '0;
            addr_q <= '0;
            timer_q <= '0;
            sda_o_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            timer_q <= timer_d;
            sda_o_q <= sda_o_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign write_busy = (state_q == tbe_pkg::TBE_WRITE);
endmodule
`default_nettype wire

// [verif/tbe_monitor.sv]
// port checker for the two-wire byte memory slave
`default_nettype none
module tbe_monitor #(
    parameter int WR_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic write_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [19:0] cnt_q;
    logic [19:0] cnt_d;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    always_comb begin
        cnt_d = write_busy ? cnt_q + 20'h1 : 20'h0;
    end
    always_ff @(posedge clk) begin
        cnt_q <= rst ? 20'h0 : cnt_d;
    end
    sequence s_drive;
        sda_oe [*8];
    endsequence
    sequence s_busy;
        write_busy [*8];
    endsequence
    property p_rst_idle; $fell(rst) |-> !sda_oe && !write_busy; endproperty
    property p_busy_quiet; write_busy |-> !sda_oe; endproperty
    property p_busy_max; write_busy |-> cnt_q < WR_CYCLES; endproperty
    property p_busy_end; $fell(write_busy) |-> $past(cnt_q) == WR_CYCLES - 1; endproperty
    property p_busy_hold; $rose(write_busy) |-> s_busy; endproperty
    property p_drive_len; $rose(sda_oe) |-> !scl ##0 s_drive; endproperty
    property p_out_low; sda_oe && $past(sda_oe) && $changed(sda_o) |-> !scl; endproperty
    property p_rel_low; $fell(sda_oe) |-> !scl; endproperty
    property p_oe_steady; scl && $past(scl) |-> $stable(sda_oe); endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive during write");
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
    a_busy_end: assert property (p_busy_end) else $error("write cycle length");
    a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");
    a_drive_len: assert property (p_drive_len) else $error("read drive short");
    a_out_low: assert property (p_out_low) else $error("output moved with clock high");
    a_rel_low: assert property (p_rel_low) else $error("release with clock high");
    a_oe_steady: assert property (p_oe_steady) else $error("enable moved with clock high");
endmodule
bind tbe_top tbe_monitor #(.WR_CYCLES(WR_CYCLES)) i_mon (.clk(clk), .rst(rst), .scl(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .write_busy(write_busy));
`default_nettype wire

// [verif/tbe_master.sv]
// bus master model: makes the serial clock and drives the data line
`default_nettype none
module tbe_master (
    input wire logic lclk,
    input wire logic sda,
    output var logic scl,
    output var logic m_d,
    output var logic m_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        m_d = 1'b1;
        m_oe = 1'b1;
    end
    // one phase: set lines, hold 40 link ticks
    task automatic st(input logic c, input logic e, input logic d);
        scl = c;
        m_oe = e;
        m_d = d;
        repeat (40) @(posedge lclk);
        #1;
    endtask
    task automatic start();
        st(1'b0, m_oe, m_d);
        st(1'b0, 1'b1, 1'b1);
        st(1'b1, 1'b1, 1'b1);
        st(1'b1, 1'b1, 1'b0);
    endtask
    task automatic stop();
        st(1'b0, m_oe, m_d);
        st(1'b0, 1'b1, 1'b0);
        st(1'b1, 1'b1, 1'b0);
        st(1'b1, 1'b1, 1'b1);
    endtask
    task automatic put(input logic b);
        st(1'b0, m_oe, m_d);
        st(1'b0, 1'b1, b);
        st(1'b1, 1'b1, b);
    endtask
    task automatic rel();
        st(1'b1, 1'b0, m_d);
    endtask
    task automatic get(output logic b);
        st(1'b0, 1'b0, m_d);
        st(1'b0, 1'b0, m_d);
        scl = 1'b1;
        b = sda;
        repeat (40) @(posedge lclk);
        #1;
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the two-wire byte memory slave
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int W = 400;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic flt = 1'b0;
    logic scl, m_d, m_oe, sda_o, sda_oe, write_busy;
    logic sda;
    logic [15:0] run = 16'h0;
    logic [15:0] len = 16'h0;
    logic [7:0] got;
    logic [11:0] rows [4] = '{12'h0a5, 12'hf5a, 12'h700, 12'h3ff};
    int n_fail = 0;
    int comparisons = 0;
    assign sda = sda_oe ? sda_o : (m_oe ? m_d : flt);
    tbe_top #(.WR_CYCLES(W)) i_dut (.clk(clk), .rst(rst), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .write_busy(write_busy));
    tbe_master i_mst (.lclk(lclk), .sda(sda), .scl(scl), .m_d(m_d), .m_oe(m_oe));
    initial forever #20 clk = ~clk;
    initial begin
        #1.7;
        forever #3 lclk = ~lclk;
    end
    always @(posedge clk) begin
        flt <= ~flt;
        run <= (write_busy === 1'b1) ? run + 16'h1 : 16'h0;
        if (write_busy !== 1'b1 && run != 16'h0) len <= run;
    end
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) i_mst.put(v[i]);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_mst.start();
        send({2'h1, a, 2'h0});
        send(d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        i_mst.start();
        send({2'h2, a, 2'h0});
        i_mst.rel();
        for (int i = 7; i >= 0; i--) i_mst.get(got[i]);
        chk(e, got);
    endtask
    task automatic wdone();
        for (int i = 0; i < 1000 && write_busy === 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
        chk(16'(W), len);
        chk(16'h0, {15'h0, write_busy});
    endtask
    task automatic stop_test();
        $display("n_fail %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        chk(16'h0, {sda_oe, write_busy});
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            wr(rows[i][11:8], rows[i][7:0]);
            wdone();
        end
        foreach (rows[i]) rd(rows[i][11:8], rows[i][7:0]);
        i_mst.start();
        send(8'h40);
        for (int i = 0; i < 4; i++) i_mst.put(1'b1);
        rd(4'h0, 8'ha5);
        i_mst.start();
        for (int i = 0; i < 4; i++) i_mst.put(i[0]);
        i_mst.stop();
        send(8'h7c);
        send(8'h11);
        rd(4'hf, 8'h5a);
        for (int c = 0; c < 4; c += 3) begin
            i_mst.start();
            send({c[1:0], 4'h7, 2'h0});
            send(8'h3c);
            rd(4'h7, 8'h00);
        end
        i_mst.start();
        send(8'h8c);
        i_mst.rel();
        i_mst.get(got[7]);
        chk(16'h1, {15'h0, got[7]});
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        chk(16'h0, {14'h0, sda_oe, write_busy});
        rd(4'h3, 8'hff);
        wr(4'h3, 8'h96);
        i_mst.start();
        send(8'h4c);
        send(8'h21);
        wdone();
        rd(4'h3, 8'h96);
        stop_test();
    end
endmodule
`default_nettype wire
